// ==== sim/sdram_cfg_checker_assertions.sv ====
`timescale 1ns/100ps
`include "sdram_cfg_defines.svh"
// ---
// Checker
// ---
module sdram_cfg_checker (
  input wire logic        pclk,              // Clock
  input wire logic        presetn,           // Reset
  input wire logic        psel,              // APB
  input wire logic        penable,           // APB
  input wire logic        pwrite,            // APB
  input wire logic [11:0] paddr,             // APB
  input wire logic [31:0] pwdata,            // APB
  input wire logic        bank_open,         // Open
  input wire logic        abort_op,          // Abort
  input wire logic        cmd_precharge_all, // Close all
  input wire logic        cmd_load_mode,     // Mode
  input wire logic [12:0] mode_value,        // Mode word
  input wire logic        init_busy,         // Busy
  input wire logic        sdram_enable,      // On
  input wire logic        mobile_mode,       // Mobile
  input wire logic        narrow_bus,        // Narrow
  input wire logic [31:0] timing_one         // Timing
);
  logic main_wr;
  logic cfg_wr;
  logic tim_wr;
  assign main_wr = psel && penable && pwrite && paddr == `OFS_MAIN_CONFIG;
  assign cfg_wr  = main_wr || (psel && penable && pwrite && paddr == `OFS_SECOND_CONFIG);
  assign tim_wr  = psel && penable && pwrite && paddr == `OFS_TIMING_ONE;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cfg_wr; cfg_wr; endsequence
  sequence s_start; abort_op && sdram_enable; endsequence
  property p_abort; s_cfg_wr |=> abort_op; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_restart; s_start |=> init_busy; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_prech; main_wr && bank_open && pwdata[`POS_IF_ON] |-> ##[1:3] cmd_precharge_all;
  endproperty
  a_prech: assert property (p_prech) else $error("no precharge");
  property p_lmr; s_start |-> ##[1:40] cmd_load_mode; endproperty
  a_lmr: assert property (p_lmr) else $error("no mode load");
  property p_cl; cmd_load_mode |-> mode_value == 13'h0020 || mode_value == 13'h0030; endproperty
  a_cl: assert property (p_cl) else $error("bad mode word");
  property p_narrow; main_wr |=> narrow_bus == $past(pwdata[`POS_NARROW]); endproperty
  a_narrow: assert property (p_narrow) else $error("bad width");
  property p_guard; $changed(mobile_mode) |-> $past(main_wr); endproperty
  a_guard: assert property (p_guard) else $error("mobile changed");
  property p_timing; $changed(timing_one) |-> $past(tim_wr); endproperty
  a_timing: assert property (p_timing) else $error("timing changed");
endmodule
bind sdram_config_fields sdram_cfg_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .bank_open, .abort_op, .cmd_precharge_all, .cmd_load_mode, .mode_value,
  .init_busy, .sdram_enable, .mobile_mode, .narrow_bus, .timing_one);

// ==== sim/sdram_partner.sv ====
`timescale 1ns/100ps
module sdram_partner (
  input  wire logic        pclk,              // Clock
  input  wire logic        presetn,           // Reset
  input  wire logic        open_req,          // Open a row
  input  wire logic        cmd_precharge_all, // Close all
  input  wire logic        cmd_load_mode,     // Mode load
  input  wire logic [12:0] mode_value,        // Mode word
  output logic             bank_open,         // Row open
  output logic      [12:0] mode_reg,          // Stored mode
  output logic      [7:0]  pre_count          // Closes seen
);
  // A row stays open until closed, so a restart that skips the close leaves it open.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_open <= 1'b0;
      mode_reg  <= 13'h0000;
      pre_count <= 8'h00;
    end else begin
      if (cmd_precharge_all) begin
        bank_open <= 1'b0;
        pre_count <= pre_count + 8'h01;
      end else if (open_req) bank_open <= 1'b1;
      if (cmd_load_mode) mode_reg <= mode_value;
    end
  end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`include "sdram_cfg_defines.svh"
module tb;
  localparam logic [11:0] MAIN = `OFS_MAIN_CONFIG;
  localparam logic [11:0] TIM = `OFS_TIMING_ONE;
  localparam logic [31:0] CFG [4] = '{32'h0081_4420, 32'h0081_4423, 32'h0081_4400, 32'h0081_4410};
  localparam logic [31:0] ADR [4] = '{32'h0000_03FF, 32'h0000_03FF, 32'h0000_03FF, 32'h0000_01FF};
  localparam logic [1:0]  BNK [4] = '{2'h3, 2'h0, 2'h0, 2'h1};
  localparam logic [10:0] COL [4] = '{11'h0FF, 11'h3FF, 11'h0FF, 11'h0FF};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        open_req = 1'b0, pready, pslverr, bank_open, abort_op, cmd_precharge_all, err;
  logic        cmd_load_mode, init_busy, sdram_enable, mobile_mode, narrow_bus;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, log_addr = 32'h0000_0000, prdata, rd;
  logic [31:0] timing_one, timing_two, second_cfg;
  logic [12:0] map_row, mode_value, mode_reg;
  logic [10:0] map_col;
  logic [7:0]  pre_count;
  logic [1:0]  map_bank;
  int          fail_count = 0, num_checks = 0;

  always #2.5 pclk = ~pclk;

  sdram_config_fields DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bank_open, .log_addr, .map_bank, .map_row, .map_col, .abort_op,
    .cmd_precharge_all, .cmd_load_mode, .mode_value, .init_busy, .sdram_enable, .mobile_mode,
    .narrow_bus, .timing_one, .timing_two, .second_cfg);
  sdram_partner mem (.pclk, .presetn, .open_req, .cmd_precharge_all, .cmd_load_mode,
    .mode_value, .bank_open, .mode_reg, .pre_count);

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Each transfer starts one edge after the last ends, so no signal is set twice in a step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_init;
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (init_busy !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) fail_count++;
    repeat (2) @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    wait_init();
  endtask

  task rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask

  task t_reset;
    wait_init();
    rd_chk("main", MAIN, 32'h0001_0620);
    chk("enable", 32'h1, 32'(sdram_enable));
    chk("mode", 32'h0030, 32'(mode_reg));
  endtask

  task t_cl;
    wr(MAIN, 32'h0001_8420);
    rd_chk("main", MAIN, 32'h0001_8420);
    chk("mode", 32'h0020, 32'(mode_reg));
    wr(MAIN, 32'h0001_0720);
    rd_chk("main", MAIN, 32'h0001_0420);
    wr(TIM, 32'h1234_5678);
    rd_chk("timing", TIM, 32'h0000_0000);
  endtask

  task t_guard;
    wr(MAIN, 32'h0A01_4420);
    rd_chk("main", MAIN, 32'h0001_4420);
    chk("narrow", 32'h1, 32'(narrow_bus));
    wr(MAIN, 32'h0081_4420);
    wr(MAIN, 32'h0A81_C420);
    rd_chk("main", MAIN, 32'h0A81_C420);
    chk("mobile", 32'h1, 32'(mobile_mode));
    wr(TIM, 32'h1234_5678);
    rd_chk("timing", TIM, 32'h1234_5678);
    wr(`OFS_TIMING_TWO, 32'h5A5A_0F0F);
    chk("timing two", 32'h5A5A_0F0F, timing_two);
  endtask

  task t_map;
    log_addr <= 32'h0060_1200;
    @(posedge pclk);
    chk("bank", 32'h3, 32'(map_bank));
    chk("row", 32'h0012, 32'(map_row));
    for (int i = 0; i < 4; i++) begin
      wr(MAIN, CFG[i]);
      log_addr <= ADR[i];
      @(posedge pclk);
      chk("bank", 32'(BNK[i]), 32'(map_bank));
      chk("column", 32'(COL[i]), 32'(map_col));
    end
  endtask

  task t_misc;
    open_req <= 1'b1;
    @(posedge pclk);
    open_req <= 1'b0;
    wr(MAIN, 32'h0081_4420);
    chk("closes", 32'h1, 32'(pre_count));
    chk("open", 32'h0, 32'(bank_open));
    wr(`OFS_SECOND_CONFIG, 32'hFFFF_FFFF);
    chk("second", 32'h0000_0707, second_cfg);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("error", 32'h1, 32'(err));
    chk("rdata", 32'h0, rd);
    wr(MAIN, 32'h0080_4420);
    chk("enable", 32'h0, 32'(sdram_enable));
  endtask

  task close_out;
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cl();
    t_guard();
    t_map();
    t_misc();
    close_out();
  end
endmodule

// ==== verilog/sdram_addr_split.sv ====
`timescale 1ns/100ps
`include "sdram_cfg_defines.svh"
// ----------------------------------------------------------------
// Logical address split into bank, row and column.
// ----------------------------------------------------------------
module sdram_addr_split (
  input  wire logic [31:0] log_addr,    // Logical word address
  input  wire logic [1:0]  internal_bank_count,       // Internal bank count code
  input  wire logic [2:0]  page,        // Page size code
  input  wire logic        bank_pos,    // Bank bits position
  input  wire logic        narrow,      // Narrow bus select
  output logic      [1:0]  bank,        // Bank address
  output logic      [12:0] row,         // Row address
  output logic      [10:0] col          // Column address
);
  logic [31:0] a;
  logic [3:0]  cbits;
  logic [1:0]  bbits;
  logic [31:0] sh;
  always_comb begin
    // A narrow bus doubles the word count per byte address.
    a     = narrow ? log_addr : (log_addr >> 1);
    cbits = 4'd8 + {2'b00, page[1:0]};
    bbits = (internal_bank_count == 2'h0) ? 2'd0 : ((internal_bank_count == 2'h1) ? 2'd1 : 2'd2);
    col   = 11'(a & ((32'h1 << cbits) - 32'h1));
    if (bank_pos) begin
      // Mobile layout: bank bits above the row.
      sh   = a >> cbits;
      row  = sh[12:0];
      sh   = sh >> 13;
      bank = sh[1:0] & ((2'b01 << bbits) - 2'b01);
    end else begin
      // Standard layout: bank bits just above the column.
      sh   = a >> cbits;
      bank = sh[1:0] & ((2'b01 << bbits) - 2'b01);
      sh   = sh >> bbits;
      row  = sh[12:0];
    end
  end
endmodule

// ==== verilog/sdram_cfg_defines.svh ====
`ifndef SDRAM_CFG_DEFINES_SVH
`define SDRAM_CFG_DEFINES_SVH

// Register byte offsets.
`define OFS_MAIN_CONFIG   12'h008
`define OFS_TIMING_ONE    12'h010
`define OFS_TIMING_TWO    12'h014
`define OFS_SECOND_CONFIG 12'h01C
`define OFS_STATUS        12'h020

// Main configuration field positions.
`define POS_BANK_POS      27
`define POS_MOBILE        25
`define POS_BOOT_UNLOCK   23
`define POS_IF_ON         16
`define POS_TIM_UNLOCK    15
`define POS_NARROW        14
`define POS_CL_LO         9
`define POS_CL_HI         11
`define POS_CS_COUNT      8
`define POS_INTERNAL_BANK_COUNT_LO      4
`define POS_INTERNAL_BANK_COUNT_HI      6
`define POS_PAGE_LO       0
`define POS_PAGE_HI       2

// Writable masks and reset values of the configuration and timing registers.
`define MAIN_CFG_MASK     32'h0A81_CF77
`define MAIN_CFG_RESET    32'h0001_0620
`define SECOND_CFG_MASK   32'h0000_0707
`define SECOND_CFG_RESET  32'h0000_0000
`define TIMING_ONE_RESET  32'h0000_0000
`define TIMING_TWO_RESET  32'h0000_0000

// Initialization sequencing.
`define INIT_WAIT_CYCLES  16'h0010
`define CL_TWO            3'h2
`define CL_THREE          3'h3

`endif

// ==== verilog/sdram_cfg_pkg.sv ====
package sdram_cfg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PRECH  = 3'b001,
    ST_WAIT   = 3'b011,
    ST_MODE   = 3'b010,
    ST_READY  = 3'b110
  } init_state_e;
endpackage

// ==== verilog/sdram_config_fields.sv ====
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "sdram_cfg_defines.svh"
module sdram_config_fields
  import sdram_cfg_pkg::*;
(
  input  wire logic        pclk,          // Controller clock
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        bank_open,     // Some bank is open
  input  wire logic [31:0] log_addr,      // Logical address to split
  output logic      [1:0]  map_bank,      // Mapped bank
  output logic      [12:0] map_row,       // Mapped row
  output logic      [10:0] map_col,       // Mapped column
  output logic             abort_op,      // Drop current operation pulse
  output logic             cmd_precharge_all, // Precharge all pulse
  output logic             cmd_load_mode, // Load mode register pulse
  output logic      [12:0] mode_value,    // Mode register value
  output logic             init_busy,     // Initialization running
  output logic             sdram_enable,  // Interface enabled
  output logic             mobile_mode,   // Mobile SDR active
  output logic             narrow_bus,    // 16-bit data bus
  output logic      [31:0] timing_one,    // Timing register one
  output logic      [31:0] timing_two,    // Timing register two
  output logic      [31:0] second_cfg     // Second configuration
);

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic hit_main;
  logic hit_t1;
  logic hit_t2;
  logic hit_c2;
  logic hit_st;
  logic mapped;
  logic cl_ok;

  // The slave never stalls, so every access phase completes at its first edge.
  always_comb begin
    acc      = psel & penable;
    wr       = acc & pwrite;
    hit_main = (paddr == `OFS_MAIN_CONFIG);
    hit_t1   = (paddr == `OFS_TIMING_ONE);
    hit_t2   = (paddr == `OFS_TIMING_TWO);
    hit_c2   = (paddr == `OFS_SECOND_CONFIG);
    hit_st   = (paddr == `OFS_STATUS);
    mapped   = hit_main | hit_t1 | hit_t2 | hit_c2 | hit_st;
    pready   = 1'b1;
    pslverr  = acc & ~mapped;
    // Only the two supported latencies may ever reach the mode register.
    cl_ok    = (pwdata[`POS_CL_HI:`POS_CL_LO] == `CL_TWO) ||
               (pwdata[`POS_CL_HI:`POS_CL_LO] == `CL_THREE);
  end

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  logic [31:0] main_q;
  logic [31:0] main_d;
  logic [31:0] t1_q;
  logic [31:0] t1_d;
  logic [31:0] t2_q;
  logic [31:0] t2_d;
  logic [31:0] c2_q;
  logic [31:0] c2_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [31:0] status_word;
  logic        restart_q;
  logic        restart_d;
  logic [31:0] nv;

  // Sequencer state is declared here because the status read below needs it.
  init_state_e st_q;
  init_state_e st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        pre_q;
  logic        pre_d;
  logic        lmr_q;
  logic        lmr_d;
  logic [12:0] mode_q;
  logic [12:0] mode_d;

  // A write to a locked field is not an error; the bus sees a normal
  // completion and the stored value simply stays as it was.

  always_comb begin
    main_d    = main_q;
    t1_d      = t1_q;
    t2_d      = t2_q;
    c2_d      = c2_q;
    restart_d = 1'b0;
    nv        = main_q;
    if (wr && hit_main) begin
      nv = (pwdata & `MAIN_CFG_MASK) | (main_q & ~`MAIN_CFG_MASK);
      if (!main_q[`POS_BOOT_UNLOCK]) begin
        // Guarded bits keep their value unless already unlocked.
        nv[`POS_BANK_POS] = main_q[`POS_BANK_POS];
        nv[`POS_MOBILE]   = main_q[`POS_MOBILE];
      end
      if (!(pwdata[`POS_TIM_UNLOCK] && cl_ok)) begin
        // Unsupported latencies are refused as well as writes without the unlock bit set.
        nv[`POS_CL_HI:`POS_CL_LO] = main_q[`POS_CL_HI:`POS_CL_LO];
      end
      nv[`POS_CS_COUNT] = 1'b0;
      main_d    = nv;
      restart_d = 1'b1;
    end
    if (wr && hit_c2) begin
      c2_d      = pwdata & `SECOND_CFG_MASK;
      restart_d = 1'b1;
    end
    if (wr && hit_t1 && main_q[`POS_TIM_UNLOCK]) begin
      t1_d = pwdata;
    end
    if (wr && hit_t2 && main_q[`POS_TIM_UNLOCK]) begin
      t2_d = pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle so that it comes from a
  // flip-flop and still stands for the whole access phase.
  always_comb begin
    prdata_d    = prdata_q;
    status_word = {29'h0000_0000, init_busy, st_q == ST_READY, bank_open};
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      if (hit_main) begin
        prdata_d = main_q;
      end else if (hit_t1) begin
        prdata_d = t1_q;
      end else if (hit_t2) begin
        prdata_d = t2_q;
      end else if (hit_c2) begin
        prdata_d = c2_q;
      end else if (hit_st) begin
        prdata_d = status_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Initialization sequencer.
  // ----------------------------------------------------------------
  // A restart overrides whatever step is running, so a second write in
  // the middle of a sequence simply begins it again from the top.
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    pre_d  = 1'b0;
    lmr_d  = 1'b0;
    mode_d = mode_q;
    case (st_q)
      ST_IDLE: begin
        if (main_q[`POS_IF_ON]) begin
          st_d  = ST_WAIT;
          cnt_d = `INIT_WAIT_CYCLES;
        end
      end
      ST_PRECH: begin
        pre_d = 1'b1;
        st_d  = ST_WAIT;
        cnt_d = `INIT_WAIT_CYCLES;
      end
      ST_WAIT: begin
        if (cnt_q == 16'h0000) begin
          st_d = ST_MODE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_MODE: begin
        lmr_d  = 1'b1;
        // Burst length field stays zero; latency sits in bits 6:4.
        mode_d = {6'h00, main_q[`POS_CL_HI:`POS_CL_LO], 4'h0};
        st_d   = ST_READY;
      end
      ST_READY: begin
        st_d = ST_READY;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (restart_q) begin
      cnt_d = `INIT_WAIT_CYCLES;
      if (!main_q[`POS_IF_ON]) begin
        st_d = ST_IDLE;
      end else if (bank_open) begin
        st_d = ST_PRECH;
      end else begin
        st_d = ST_WAIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file flip-flops.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q    <= `MAIN_CFG_RESET;
      t1_q      <= `TIMING_ONE_RESET;
      t2_q      <= `TIMING_TWO_RESET;
      c2_q      <= `SECOND_CFG_RESET;
      restart_q <= 1'b0;
    end else begin
      main_q    <= main_d;
      t1_q      <= t1_d;
      t2_q      <= t2_d;
      c2_q      <= c2_d;
      restart_q <= restart_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data flip-flop.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer flip-flops.
  // ----------------------------------------------------------------
  // The command strobes are registered so the memory side sees clean
  // one-cycle pulses with no decode glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 16'h0000;
      pre_q  <= 1'b0;
      lmr_q  <= 1'b0;
      mode_q <= 13'h0000;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      pre_q  <= pre_d;
      lmr_q  <= lmr_d;
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  always_comb begin
    prdata            = prdata_q;
    abort_op          = restart_q;
    cmd_precharge_all = pre_q;
    cmd_load_mode     = lmr_q;
    mode_value        = mode_q;
    init_busy         = (st_q != ST_READY) && (st_q != ST_IDLE);
    sdram_enable      = main_q[`POS_IF_ON];
    // Mobile operation depends on software setting both bits.
    mobile_mode       = main_q[`POS_IF_ON] & main_q[`POS_MOBILE];
    narrow_bus        = main_q[`POS_NARROW];
    timing_one        = t1_q;
    timing_two        = t2_q;
    second_cfg        = c2_q;
  end

  sdram_addr_split u_split (
    .log_addr (log_addr),
    .internal_bank_count    (main_q[`POS_INTERNAL_BANK_COUNT_HI-1:`POS_INTERNAL_BANK_COUNT_LO]),
    .page     (main_q[`POS_PAGE_HI:`POS_PAGE_LO]),
    .bank_pos (main_q[`POS_BANK_POS]),
    .narrow   (main_q[`POS_NARROW]),
    .bank     (map_bank),
    .row      (map_row),
    .col      (map_col)
  );

endmodule
